// ---- tb/gmrp_client.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmrp_client
	import gmrp_pkg::*;
(
	// Clock
	input  wire logic       core_clk_i,
	// Requests towards the port
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_last_o,
	input  wire logic       rx_ready_i,
	// Responses from the port
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_last_i,
	output logic            tx_ready_o
);
	logic [7:0] req [0:31];
	logic [7:0] rsp [0:31];
	int         rsp_len;
	logic       stall;

	initial
	begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h5A;
		rx_last_o  = 1'b0;
		tx_ready_o = 1'b0;
	end

	// Sends one whole frame, then takes the reply; the idle data line inverts.
	task automatic transact(input int n);
		int k;
		rsp_len = 0;
		for (int i = 0; i < n; i++)
		begin
			@(negedge core_clk_i);
			rx_valid_o = 1'b1;
			rx_data_o  = req[i];
			rx_last_o  = (i == n - 1);
			k = 0;
			while (rx_ready_i !== 1'b1 && k < 100)
			begin
				@(negedge core_clk_i);
				k++;
			end
		end
		@(negedge core_clk_i);
		rx_valid_o = 1'b0;
		rx_last_o  = 1'b0;
		rx_data_o  = ~rx_data_o;
		for (k = 0; k < 200 && rsp_len < 32; k++)
		begin
			tx_ready_o = stall ? 1'(($urandom() % 3) == 0) : 1'b1;
			if (tx_valid_i === 1'b1 && tx_ready_o)
			begin
				rsp[rsp_len] = tx_data_i;
				rsp_len++;
				if (tx_last_i === 1'b1)
					break;
			end
			@(negedge core_clk_i);
		end
	endtask : transact
endmodule : gmrp_client
`default_nettype wire

// ---- tb/gmrp_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmrp_port_tb
	import gmrp_pkg::*;
;
	logic        core_clk_i;
	logic        reset_i;
	logic        rx_valid_i;
	logic [7:0]  rx_data_i;
	logic        rx_last_i;
	logic        rx_ready_o;
	logic        tx_valid_o;
	logic [7:0]  tx_data_o;
	logic        tx_last_o;
	logic        tx_ready_i;
	logic        activation_done_i;
	logic [95:0] status_bytes_i;
	logic        activate_request_bit_o;
	logic [1:0]  activation_state_field_o;
	logic [3:0]  cmd_rd_addr_i;
	logic [7:0]  cmd_rd_data_o;
	logic [7:0]  exp [0:31];
	int          exp_len;
	logic        act_e;
	logic [1:0]  st_e;
	logic [47:0] wd;
	int          n_fail;
	int          check_count;
	int          cycles;

	gmrp_port #(.REFRESH(20)) gmrp_port_inst (
		.core_clk_i(core_clk_i), .reset_i(reset_i),
		.rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.rx_last_i(rx_last_i), .rx_ready_o(rx_ready_o),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
		.tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i),
		.activation_done_i(activation_done_i),
		.status_bytes_i(status_bytes_i),
		.activate_request_bit_o(activate_request_bit_o),
		.activation_state_field_o(activation_state_field_o),
		.cmd_rd_addr_i(cmd_rd_addr_i), .cmd_rd_data_o(cmd_rd_data_o));

	gmrp_client gmrp_client_inst (
		.core_clk_i(core_clk_i), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .rx_last_o(rx_last_i),
		.rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o),
		.tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
		.tx_ready_o(tx_ready_i));

	always #2.5 core_clk_i = ~core_clk_i;

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			n_fail++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] expv);
		check_count++;
		if (seen !== expv)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, expv, seen);
		end
	endtask : check

	task automatic cmp_rsp();
		check("reply length", 16'(gmrp_client_inst.rsp_len),
			16'(exp_len));
		for (int i = 0; i < exp_len; i++)
			check("reply byte", 16'(gmrp_client_inst.rsp[i]),
				16'(exp[i]));
	endtask : cmp_rsp

	function automatic logic [7:0] img(input int i);
		if (i == 0)
			return {2'b00, st_e, 3'b000, act_e};
		if (i == 1 || i >= 12)
			return 8'h00;
		return status_bytes_i[8*i +: 8];
	endfunction : img

	task automatic mk(input logic [15:0] tid, len, input logic [7:0] unit,
		fc, input logic [15:0] cnt, input logic [15:0] adr = 16'h0000);
		logic [7:0] h [0:11];
		h = '{tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0],
			unit, fc, adr[15:8], adr[7:0], cnt[15:8], cnt[7:0]};
		for (int i = 0; i < 12; i++)
			gmrp_client_inst.req[i] = h[i];
		for (int i = 0; i < 12; i++)
			exp[i] = h[i];
		exp[4] = 8'h00;
	endtask : mk

	task automatic wr(input logic [15:0] tid, input logic [7:0] unit, fc,
		input logic [47:0] d);
		mk(tid, 16'h000D, unit, fc, 16'h0003);
		gmrp_client_inst.req[12] = 8'h06;
		for (int i = 0; i < 6; i++)
			gmrp_client_inst.req[13+i] = d[47-8*i -: 8];
		exp[5] = 8'h06;
		exp_len = (unit == UNIT_ID_DEFAULT && fc == FC_WRITE_MULTI) ? 12 : 0;
		gmrp_client_inst.transact(19);
	endtask : wr

	task automatic rd(input logic [15:0] tid, input logic [7:0] unit, fc,
		input int cnt, input int adr = 0);
		mk(tid, 16'h0006, unit, fc, 16'(cnt), 16'(adr));
		exp[5] = 8'(3 + 2 * cnt);
		exp[8] = 8'(2 * cnt);
		for (int i = 0; i < 2 * cnt; i++)
			exp[9+i] = img(2 * adr + i);
		exp_len = (unit == UNIT_ID_DEFAULT && fc == FC_READ_INPUT) ? 9+2*cnt : 0;
		repeat (25) @(negedge core_clk_i);
		gmrp_client_inst.transact(12);
	endtask : rd

	initial
	begin
		core_clk_i = 1'b0;
		reset_i = 1'b1;
		activation_done_i = 1'b0;
		status_bytes_i = '0;
		cmd_rd_addr_i = 4'h0;
		n_fail = 0;
		check_count = 0;
		gmrp_client_inst.stall = 1'b0;
		void'($urandom(32'h63e1_3a7b));
		repeat (20) @(posedge core_clk_i);
		@(negedge core_clk_i);
		reset_i = 1'b0;
		check("ready after reset", 16'(rx_ready_o), 16'h0001);
		check("valid after reset", 16'(tx_valid_o), 16'h0000);
		wr(16'h339A, UNIT_ID_DEFAULT, FC_WRITE_MULTI, 48'h0100_0000_0000);
		cmp_rsp();
		act_e = 1'b1;
		st_e = ACT_BUSY;
		check("activate", 16'(activate_request_bit_o), 16'h0001);
		gmrp_client_inst.stall = 1'b1;
		rd(16'h4533, UNIT_ID_DEFAULT, FC_READ_INPUT, 1);
		cmp_rsp();
		activation_done_i = 1'b1;
		status_bytes_i = {$urandom(), $urandom(), $urandom()};
		st_e = ACT_DONE;
		rd(16'($urandom()), UNIT_ID_DEFAULT, FC_READ_INPUT, 6);
		cmp_rsp();
		rd(16'($urandom()), UNIT_ID_DEFAULT, FC_READ_INPUT, 8);
		cmp_rsp();
		gmrp_client_inst.stall = 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			if (k < 3)
				wr(16'($urandom()), k == 0 ? 8'h03 : UNIT_ID_DEFAULT,
					k == 1 ? 8'h03 : 8'h06, 48'h0);
			else
				rd(16'($urandom()), 8'h07, FC_READ_INPUT, 1);
			cmp_rsp();
			check("no access", 16'(activate_request_bit_o), 16'h0001);
		end
		for (int k = 0; k < 4; k++)
		begin
			wd = {$urandom(), 16'($urandom())};
			wr(16'($urandom()), UNIT_ID_DEFAULT, FC_WRITE_MULTI, wd);
			cmp_rsp();
			act_e = wd[40];
			st_e = act_e ? ACT_DONE : ACT_IDLE;
			check("activate", 16'(activate_request_bit_o), 16'(act_e));
			check("state", 16'(activation_state_field_o), 16'(st_e));
			for (int a = 0; a < 6; a++)
			begin
				cmd_rd_addr_i = 4'(a);
				@(negedge core_clk_i);
				check("command byte", 16'(cmd_rd_data_o), 16'(wd[47-8*a -: 8]));
			end
		end
		rd(16'($urandom()), UNIT_ID_DEFAULT, FC_READ_INPUT, 2);
		cmp_rsp();
		rd(16'($urandom()), UNIT_ID_DEFAULT, FC_READ_INPUT, 2, 4);
		cmp_rsp();
		complete_run();
	end
endmodule : gmrp_port_tb
`default_nettype wire

// ---- verilog/gmrp_cmd_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmrp_cmd_mem
	import gmrp_pkg::*;
#(
	parameter int DEPTH = NUM_OUT_BYTES_DEF,
	parameter int AW    = 4
) (
	// Clock
	input  wire logic          core_clk_i,
	// Write port
	input  wire logic          wr_en_i,
	input  wire logic [AW-1:0] wr_addr_i,
	input  wire logic [7:0]    wr_data_i,
	// Read port
	input  wire logic [AW-1:0] rd_addr_i,
	output logic      [7:0]    rd_data_o
);

	logic [7:0] mem [DEPTH];

	always_ff @(posedge core_clk_i)
	begin
		if (wr_en_i)
		begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		rd_data_o <= mem[rd_addr_i];
	end

endmodule : gmrp_cmd_mem
`default_nettype wire

// ---- verilog/gmrp_pkg.sv ----
// Functional notes
// - Response starts with the request's transaction id and a zero protocol id.
// - Read reply carries function 04, byte count, two bytes per register.
// - Read reply length counts unit id, function, byte count and data.
// - One register read gives byte count 2 and exactly two data bytes.
// - Function 16 writes consecutive output registers from the given address.
// - Write reply has length six, echoes ids, address and count.
// - Command word zero high byte is action request; bit 0 activates.
// - Activation in progress reports status byte 0x11.
// - Activation completed reports status byte 0x31.
// - Register image refreshes at 200 Hz; reads 5 ms apart advised.
// - Each word is two device bytes; lower byte number is high byte.
package gmrp_pkg;

	localparam logic [7:0]  FC_READ_INPUT    = 8'h04;
	localparam logic [7:0]  FC_WRITE_MULTI   = 8'h10;
	localparam logic [7:0]  UNIT_ID_DEFAULT  = 8'h02;
	localparam logic [15:0] PROTOCOL_ID      = 16'h0000;
	localparam logic [15:0] WRITE_RESP_LEN   = 16'h0006;
	localparam logic [15:0] READ_LEN_BASE    = 16'h0003;
	localparam logic [15:0] WRITE_RESP_LAST  = 16'h000B;

	// Byte positions inside a request or response frame.
	localparam logic [15:0] IDX_TID_HI   = 16'h0000;
	localparam logic [15:0] IDX_TID_LO   = 16'h0001;
	localparam logic [15:0] IDX_LEN_HI   = 16'h0004;
	localparam logic [15:0] IDX_LEN_LO   = 16'h0005;
	localparam logic [15:0] IDX_UNIT     = 16'h0006;
	localparam logic [15:0] IDX_FUNC     = 16'h0007;
	localparam logic [15:0] IDX_ADDR_HI  = 16'h0008;
	localparam logic [15:0] IDX_ADDR_LO  = 16'h0009;
	localparam logic [15:0] IDX_CNT_HI   = 16'h000A;
	localparam logic [15:0] IDX_CNT_LO   = 16'h000B;
	localparam logic [15:0] IDX_WR_DATA  = 16'h000D;
	localparam logic [15:0] IDX_RD_COUNT = 16'h0008;
	localparam logic [15:0] IDX_RD_DATA  = 16'h0009;

	// Status byte layout.
	localparam int          ECHO_BIT     = 0;
	localparam int          STATE_LSB    = 4;
	localparam int          ACT_REQ_BIT  = 0;
	localparam logic [1:0]  ACT_IDLE     = 2'h0;
	localparam logic [1:0]  ACT_BUSY     = 2'h1;
	localparam logic [1:0]  ACT_DONE     = 2'h3;

	localparam int NUM_IN_BYTES_DEF  = 12;
	localparam int NUM_OUT_BYTES_DEF = 16;

	// Refresh of the input image.
	localparam int CLK_PERIOD_NS   = 5;
	localparam int REFRESH_TIME_NS = 5_000_000;
	localparam int REFRESH_CYCLES  = REFRESH_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [0:0] {
		GMRP_RX,
		GMRP_TX
	} gmrp_state_e;

endpackage : gmrp_pkg

// ---- verilog/gmrp_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module gmrp_port
	import gmrp_pkg::*;
#(
	parameter logic [7:0] UNIT_ID       = UNIT_ID_DEFAULT,
	parameter int         NUM_IN_BYTES  = NUM_IN_BYTES_DEF,
	parameter int         NUM_OUT_BYTES = NUM_OUT_BYTES_DEF,
	parameter int         OUT_AW        = 4,
	parameter int         REFRESH       = REFRESH_CYCLES
) (
	// Clock and reset
	input  wire logic                    core_clk_i,
	input  wire logic                    reset_i,
	// Request byte stream
	input  wire logic                    rx_valid_i,
	input  wire logic [7:0]              rx_data_i,
	input  wire logic                    rx_last_i,
	output logic                         rx_ready_o,
	// Response byte stream
	output logic                         tx_valid_o,
	output logic      [7:0]              tx_data_o,
	output logic                         tx_last_o,
	input  wire logic                    tx_ready_i,
	// Gripper side
	input  wire logic                    activation_done_i,
	input  wire logic [8*NUM_IN_BYTES-1:0] status_bytes_i,
	output logic                         activate_request_bit_o,
	output logic      [1:0]              activation_state_field_o,
	input  wire logic [OUT_AW-1:0]       cmd_rd_addr_i,
	output logic      [7:0]              cmd_rd_data_o
);

	gmrp_state_e state;
	logic [15:0] rx_idx;
	logic [15:0] tx_idx;
	logic [15:0] tid;
	logic [7:0]  unit;
	logic [7:0]  func;
	logic [15:0] start_addr;
	logic [15:0] reg_count;
	logic [7:0]  image [NUM_IN_BYTES];
	logic [31:0] refresh_cnt;
	logic        refresh_tick;
	logic [1:0]  act_state;
	logic [7:0]  status_byte;
	logic        rx_take;
	logic        tx_take;
	logic        req_ok;
	logic        is_read;
	logic [15:0] wr_byte_addr;
	logic        wr_en;
	logic [15:0] ld_idx;
	logic [15:0] rd_byte_addr;
	logic [15:0] resp_len;
	logic [15:0] resp_last;
	logic [7:0]  next_byte;

	assign rx_ready_o = (state == GMRP_RX);
	assign tx_valid_o = (state == GMRP_TX);
	assign rx_take    = rx_valid_i && rx_ready_o;
	assign tx_take    = tx_valid_o && tx_ready_i;
	assign is_read    = (func == FC_READ_INPUT);
	assign req_ok     = (unit == UNIT_ID) && (is_read || func == FC_WRITE_MULTI);
	assign tx_last_o  = tx_valid_o && (tx_idx == resp_last);

	// Word address times two plus byte offset; even byte is the high byte.
	assign wr_byte_addr = {start_addr[14:0], 1'b0} + (rx_idx - IDX_WR_DATA);
	assign wr_en = rx_take && req_ok && !is_read && rx_idx >= IDX_WR_DATA
		&& wr_byte_addr < 16'(NUM_OUT_BYTES);

	assign resp_len  = is_read ? READ_LEN_BASE + {reg_count[14:0], 1'b0}
		: WRITE_RESP_LEN;
	assign resp_last = is_read ? IDX_RD_COUNT + {reg_count[14:0], 1'b0}
		: WRITE_RESP_LAST;

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			state <= GMRP_RX;
		else
		begin
			case (state)
				GMRP_RX:
					if (rx_take && rx_last_i && req_ok && rx_idx >= IDX_CNT_LO)
						state <= GMRP_TX;
				GMRP_TX:
					if (tx_take && tx_last_o)
						state <= GMRP_RX;
				default:
					state <= GMRP_RX;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			rx_idx <= 16'h0000;
		else if (rx_take && rx_last_i)
			rx_idx <= 16'h0000;
		else if (rx_take && rx_idx != 16'hFFFF)
			rx_idx <= rx_idx + 16'h0001;
	end

	// Header fields are captured as they stream past.
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			tid        <= 16'h0000;
			unit       <= 8'h00;
			func       <= 8'h00;
			start_addr <= 16'h0000;
			reg_count  <= 16'h0000;
		end
		else if (rx_take)
		begin
			case (rx_idx)
				IDX_TID_HI:  tid[15:8]        <= rx_data_i;
				IDX_TID_LO:  tid[7:0]         <= rx_data_i;
				IDX_UNIT:    unit             <= rx_data_i;
				IDX_FUNC:    func             <= rx_data_i;
				IDX_ADDR_HI: start_addr[15:8] <= rx_data_i;
				IDX_ADDR_LO: start_addr[7:0]  <= rx_data_i;
				IDX_CNT_HI:  reg_count[15:8]  <= rx_data_i;
				IDX_CNT_LO:  reg_count[7:0]   <= rx_data_i;
				default:     unit             <= unit;
			endcase
		end
	end

	gmrp_cmd_mem #(
		.DEPTH (NUM_OUT_BYTES),
		.AW    (OUT_AW)
	) u_cmd_mem (
		.core_clk_i (core_clk_i),
		.wr_en_i    (wr_en),
		.wr_addr_i  (wr_byte_addr[OUT_AW-1:0]),
		.wr_data_i  (rx_data_i),
		.rd_addr_i  (cmd_rd_addr_i),
		.rd_data_o  (cmd_rd_data_o)
	);

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			activate_request_bit_o <= 1'b0;
		else if (wr_en && wr_byte_addr == 16'h0000)
			activate_request_bit_o <= rx_data_i[ACT_REQ_BIT];
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i || !activate_request_bit_o)
			act_state <= ACT_IDLE;
		else if (activation_done_i)
			act_state <= ACT_DONE;
		else if (act_state == ACT_IDLE)
			act_state <= ACT_BUSY;
	end
	assign activation_state_field_o = act_state;

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[ECHO_BIT] = activate_request_bit_o;
		status_byte[STATE_LSB +: 2] = act_state;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i || refresh_tick)
			refresh_cnt <= 32'h0000_0000;
		else
			refresh_cnt <= refresh_cnt + 32'h0000_0001;
	end
	assign refresh_tick = (refresh_cnt == 32'(REFRESH - 1));

	// Input image, sampled once per refresh period.
	for (genvar i = 0; i < NUM_IN_BYTES; i++)
	begin : g_image
		always_ff @(posedge core_clk_i)
		begin
			if (reset_i)
				image[i] <= 8'h00;
			else if (refresh_tick)
			begin
				if (i == 0)
					image[i] <= status_byte;
				else if (i == 1)
					image[i] <= 8'h00;
				else
					image[i] <= status_bytes_i[8*i +: 8];
			end
		end
	end

	assign ld_idx = (state == GMRP_RX) ? 16'h0000 : tx_idx + 16'h0001;
	assign rd_byte_addr = {start_addr[14:0], 1'b0} + (ld_idx - IDX_RD_DATA);

	always_comb
	begin
		next_byte = 8'h00;
		case (ld_idx)
			IDX_TID_HI: next_byte = tid[15:8];
			IDX_TID_LO: next_byte = tid[7:0];
			IDX_LEN_HI: next_byte = resp_len[15:8];
			IDX_LEN_LO: next_byte = resp_len[7:0];
			IDX_UNIT:   next_byte = unit;
			IDX_FUNC:   next_byte = func;
			16'h0002, 16'h0003: next_byte = PROTOCOL_ID[7:0];
			default:
				if (!is_read)
				begin
					case (ld_idx)
						IDX_ADDR_HI: next_byte = start_addr[15:8];
						IDX_ADDR_LO: next_byte = start_addr[7:0];
						IDX_CNT_HI:  next_byte = reg_count[15:8];
						IDX_CNT_LO:  next_byte = reg_count[7:0];
						default:     next_byte = 8'h00;
					endcase
				end
				else if (ld_idx == IDX_RD_COUNT)
					next_byte = {reg_count[6:0], 1'b0};
				else if (rd_byte_addr < 16'(NUM_IN_BYTES))
					next_byte = image[rd_byte_addr[$clog2(NUM_IN_BYTES)-1:0]];
		endcase
	end

	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			tx_idx    <= 16'h0000;
			tx_data_o <= 8'h00;
		end
		else if (state == GMRP_RX)
		begin
			tx_idx    <= 16'h0000;
			tx_data_o <= next_byte;
		end
		else if (tx_take)
		begin
			tx_idx    <= ld_idx;
			tx_data_o <= next_byte;
		end
	end

	sequence s_resp_done;
		tx_valid_o && tx_ready_i && tx_last_o;
	endsequence

	sequence s_good_end;
		rx_take && rx_last_i && req_ok && rx_idx >= IDX_CNT_LO;
	endsequence

	a_tid_echo: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_good_end |=> tx_valid_o && tx_data_o == tid[15:8] && tx_idx == 0)
		else $error("transaction id high byte not echoed");
	a_pid_zero: assert property (@(posedge core_clk_i) disable iff (reset_i)
		tx_valid_o && (tx_idx == 2 || tx_idx == 3) |-> tx_data_o == 8'h00)
		else $error("protocol id not zero");
	a_read_len: assert property (@(posedge core_clk_i) disable iff (reset_i)
		tx_valid_o && is_read && tx_idx == 5
		|-> tx_data_o == 8'(3 + 2 * reg_count))
		else $error("read length wrong");
	a_read_cnt: assert property (@(posedge core_clk_i) disable iff (reset_i)
		tx_valid_o && is_read && tx_idx == 8
		|-> tx_data_o == 8'(2 * reg_count) && tx_last_o == (reg_count == 0))
		else $error("read byte count wrong");
	a_func_echo: assert property (@(posedge core_clk_i) disable iff (reset_i)
		tx_valid_o && tx_idx == 7 |-> tx_data_o == func
		&& (func == 8'h04 || func == 8'h10))
		else $error("function code not echoed");
	a_write_len: assert property (@(posedge core_clk_i) disable iff (reset_i)
		tx_valid_o && !is_read && tx_idx == 5 |-> tx_data_o == 8'h06)
		else $error("write length not six");
	a_write_end: assert property (@(posedge core_clk_i) disable iff (reset_i)
		tx_valid_o && !is_read |-> tx_last_o == (tx_idx == 11))
		else $error("write response not twelve bytes");
	a_no_access: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_en |-> unit == UNIT_ID && func == 8'h10 && rx_idx > 12)
		else $error("register write from bad request");
	a_status_map: assert property (@(posedge core_clk_i) disable iff (reset_i)
		activate_request_bit_o && !activation_done_i && act_state == ACT_BUSY
		|-> status_byte == 8'h11 ##1 act_state != ACT_IDLE
		|| !activate_request_bit_o)
		else $error("status byte wrong in progress");
	a_status_done: assert property (@(posedge core_clk_i) disable iff (reset_i)
		activate_request_bit_o && activation_done_i
		|=> status_byte == 8'h31 || !activate_request_bit_o)
		else $error("status byte wrong after completion");
	a_act_write: assert property (@(posedge core_clk_i) disable iff (reset_i)
		wr_en && wr_byte_addr == 0
		|=> activate_request_bit_o == $past(rx_data_i[0]))
		else $error("activate bit not taken from high byte");
	a_refresh: assert property (@(posedge core_clk_i) disable iff (reset_i)
		refresh_tick |=> image[0] == $past(status_byte)
		&& refresh_cnt == 0)
		else $error("image not refreshed");
	a_back_rx: assert property (@(posedge core_clk_i) disable iff (reset_i)
		s_resp_done |=> rx_ready_o && !tx_valid_o)
		else $error("no return to receive");

endmodule : gmrp_port
`default_nettype wire
